// *** hw/pnprt_pkg.sv ***
// Constants for the plug and play resource routing and nonvolatile store block
package pnprt_pkg;
   localparam logic [7:0] REG_STATUS = 8'h05;
   localparam logic [7:0] REG_COMMAND = 8'hf0;
   localparam logic [7:0] REG_ADDR_LOW = 8'hf1;
   localparam logic [7:0] REG_DATA_HIGH = 8'hf2;
   localparam logic [7:0] REG_DATA_LOW = 8'hf3;

   localparam int CMD_OP_LSB = 0;
   localparam int CMD_PROCEED_BIT = 2;
   localparam int CMD_ADDR9_BIT = 7;
   localparam int STATUS_DONE_BIT = 0;
   localparam logic [7:0] CMD_RESET = 8'h00;
   localparam logic [7:0] CMD_WRITABLE = 8'h87;

   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_ERASE = 2'h3;
   localparam logic [15:0] ERASED_WORD = 16'hffff;

   localparam logic [1:0] MODE_DMA = 2'h0;
   localparam logic [1:0] MODE_EXT_IRQ = 2'h1;

   localparam int STORE_WORDS = 384;
   localparam int WORD_BITS = 16;
   localparam int SERIAL_ADDR_BITS = 8;
   localparam int SERIAL_CMD_BITS = 10;
   localparam int SERIAL_CNT_BITS = 5;

   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned PROG_TIME_NS = 10000000;
   localparam int unsigned READ_CYCLES = 1;
   localparam int TIMER_BITS = 21;

   typedef enum logic [3:0] {
      SER_IDLE = 4'b0001,
      SER_CMD = 4'b0010,
      SER_OUT = 4'b0100,
      SER_IN = 4'b1000
   } pnprt_ser_e;
endpackage

// *** hw/pnprt_chip_select.sv ***
// One programmable I/O chip select decoder
`timescale 1ns/1ns
module pnprt_chip_select
   import pnprt_pkg::*;
#(
   parameter int ADDR_BITS = 16
) (
   input wire logic [ADDR_BITS-1:0] addr,
   input wire logic [ADDR_BITS-1:0] base,
   input wire logic [ADDR_BITS-1:0] mask,
   input wire logic enable,
   input wire logic qualify,
   input wire logic addr_en,
   input wire logic iord_n,
   input wire logic iowr_n,
   output logic cs_n
);
   logic match;
   always_comb begin
      match = enable && !addr_en && ((addr & mask) == (base & mask));
      if (qualify) begin
         match = match && (!iord_n || !iowr_n);
      end
      cs_n = !match;
   end
endmodule

// *** hw/pnprt_top.sv ***
// Resource routing, chip selects and nonvolatile store with host and serial access
`timescale 1ns/1ns
module pnprt_top
   import pnprt_pkg::*;
#(
   parameter int unsigned PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [11:0] sa,
   input wire logic iord_n,
   input wire logic iowr_n,
   input wire logic aen,
   input wire logic config_state,
   input wire logic [7:0] reg_index,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic [1:0] mode_select_bits,
   input wire logic [2:0] irq_route0,
   input wire logic [2:0] irq_route1,
   input wire logic irq_enable0,
   input wire logic irq_enable1,
   input wire logic dma_enable,
   input wire logic dma_channel,
   input wire logic [15:0] cs_base0,
   input wire logic [15:0] cs_base1,
   input wire logic [15:0] cs_base2,
   input wire logic [15:0] cs_mask0,
   input wire logic [15:0] cs_mask1,
   input wire logic [15:0] cs_mask2,
   input wire logic [2:0] cs_enable,
   input wire logic [2:0] cs_qualify,
   input wire logic [1:0] board_irq_in,
   input wire logic board_dma_req,
   output logic board_dma_ack_n,
   output logic [5:0] host_irq_out,
   output logic [1:0] host_dma_req_out,
   input wire logic [1:0] host_dma_ack_in_n,
   output logic [1:0] card_chip_select_n,
   input wire logic serial_port_select,
   input wire logic serial_port_clock,
   input wire logic serial_port_in,
   output logic serial_port_out
);
   // ----------------------------------------------------------------
   // Mode pin sharing and routing
   // ----------------------------------------------------------------
   logic ext_mode;
   logic [15:0] full_addr;
   logic [2:0] cs_n;
   logic [7:0] irq_lines;
   logic third_chip_select_n;

   always_comb begin
      ext_mode = (mode_select_bits == MODE_EXT_IRQ);
      full_addr = ext_mode ? {board_dma_req, board_irq_in[1], host_dma_ack_in_n, sa}
                           : {4'h0, sa};
      irq_lines = '0;
      if (irq_enable0) begin
         irq_lines[irq_route0] = board_irq_in[0];
      end
      if (irq_enable1 && !ext_mode) begin
         irq_lines[irq_route1] = irq_lines[irq_route1] | board_irq_in[1];
      end
      host_irq_out = irq_lines[5:0];
      third_chip_select_n = cs_n[2];
      if (ext_mode) begin
         host_dma_req_out = irq_lines[7:6];
         board_dma_ack_n = third_chip_select_n;
      end else begin
         host_dma_req_out = '0;
         host_dma_req_out[dma_channel] = dma_enable && board_dma_req;
         board_dma_ack_n = !dma_enable || host_dma_ack_in_n[dma_channel];
      end
      card_chip_select_n = cs_n[1:0];
   end

   pnprt_chip_select #(.ADDR_BITS(16)) u_cs0 (
      .addr(full_addr), .base(cs_base0), .mask(cs_mask0), .enable(cs_enable[0]),
      .qualify(cs_qualify[0]), .addr_en(aen), .iord_n(iord_n), .iowr_n(iowr_n),
      .cs_n(cs_n[0])
   );
   pnprt_chip_select #(.ADDR_BITS(16)) u_cs1 (
      .addr(full_addr), .base(cs_base1), .mask(cs_mask1), .enable(cs_enable[1]),
      .qualify(cs_qualify[1]), .addr_en(aen), .iord_n(iord_n), .iowr_n(iowr_n),
      .cs_n(cs_n[1])
   );
   pnprt_chip_select #(.ADDR_BITS(16)) u_cs2 (
      .addr(full_addr), .base(cs_base2), .mask(cs_mask2),
      .enable(cs_enable[2] && ext_mode), .qualify(cs_qualify[2]), .addr_en(aen),
      .iord_n(iord_n), .iowr_n(iowr_n), .cs_n(cs_n[2])
   );

   // ----------------------------------------------------------------
   // Nonvolatile store
   // ----------------------------------------------------------------
   logic [WORD_BITS-1:0] store_mem [STORE_WORDS];
   logic mem_we;
   logic [8:0] mem_waddr;
   logic [WORD_BITS-1:0] mem_wdata;

   always_ff @(posedge sys_clk) begin
      if (mem_we) begin
         store_mem[mem_waddr] <= mem_wdata;
      end
   end

   // ----------------------------------------------------------------
   // Host programming registers
   // ----------------------------------------------------------------
   logic [7:0] cmd_q, cmd_d;
   logic [7:0] addr_q, addr_d;
   logic [7:0] data_hi_q, data_hi_d;
   logic [7:0] data_lo_q, data_lo_d;
   logic busy_q, busy_d;
   logic [TIMER_BITS-1:0] timer_q, timer_d;
   logic [7:0] rdata_q, rdata_d;
   logic prog_wr, prog_rd, start, finish;
   logic [8:0] host_addr;
   logic [1:0] op;
   logic host_we;
   logic [WORD_BITS-1:0] host_word;

   always_comb begin
      prog_wr = reg_wr && config_state;
      prog_rd = reg_rd && config_state;
      host_addr = {cmd_q[CMD_ADDR9_BIT], addr_q};
      op = cmd_q[CMD_OP_LSB +: 2];
      cmd_d = cmd_q;
      addr_d = addr_q;
      data_hi_d = data_hi_q;
      data_lo_d = data_lo_q;
      busy_d = busy_q;
      timer_d = timer_q;
      start = 1'b0;
      host_we = 1'b0;
      host_word = {data_hi_q, data_lo_q};
      finish = busy_q && (timer_q == TIMER_BITS'(1));
      if (prog_wr && !busy_q) begin
         case (reg_index)
            REG_COMMAND: begin
               cmd_d = reg_wdata & CMD_WRITABLE;
               start = reg_wdata[CMD_PROCEED_BIT] && (reg_wdata[CMD_OP_LSB +: 2] != 2'h0);
            end
            REG_ADDR_LOW: addr_d = reg_wdata;
            REG_DATA_HIGH: data_hi_d = reg_wdata;
            REG_DATA_LOW: data_lo_d = reg_wdata;
            default: ;
         endcase
      end
      if (start) begin
         busy_d = 1'b1;
         timer_d = (reg_wdata[CMD_OP_LSB +: 2] == OP_READ) ? TIMER_BITS'(READ_CYCLES)
                                               : TIMER_BITS'(PROG_CYCLES);
      end else if (busy_q) begin
         timer_d = timer_q - TIMER_BITS'(1);
      end
      if (finish) begin
         busy_d = 1'b0;
         cmd_d[CMD_PROCEED_BIT] = 1'b0;
         case (op)
            OP_READ: begin
               data_hi_d = store_mem[host_addr][WORD_BITS-1 -: 8];
               data_lo_d = store_mem[host_addr][0 +: 8];
            end
            OP_WRITE: host_we = 1'b1;
            OP_ERASE: begin
               host_we = 1'b1;
               host_word = ERASED_WORD;
            end
            default: ;
         endcase
      end
      rdata_d = rdata_q;
      if (reg_rd) begin
         rdata_d = 8'h00;
         if (reg_index == REG_STATUS) begin
            rdata_d[STATUS_DONE_BIT] = !busy_q;
         end else if (prog_rd) begin
            case (reg_index)
               REG_COMMAND: rdata_d = cmd_q;
               REG_ADDR_LOW: rdata_d = addr_q;
               REG_DATA_HIGH: rdata_d = data_hi_q;
               REG_DATA_LOW: rdata_d = data_lo_q;
               default: rdata_d = 8'h00;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cmd_q <= CMD_RESET;
         addr_q <= '0;
         data_hi_q <= '0;
         data_lo_q <= '0;
         busy_q <= 1'b0;
         timer_q <= '0;
         rdata_q <= '0;
      end else begin
         cmd_q <= cmd_d;
         addr_q <= addr_d;
         data_hi_q <= data_hi_d;
         data_lo_q <= data_lo_d;
         busy_q <= busy_d;
         timer_q <= timer_d;
         rdata_q <= rdata_d;
      end
   end
   assign reg_rdata = rdata_q;

   // ----------------------------------------------------------------
   // Serial port for on-board logic (low 4 kbits)
   // ----------------------------------------------------------------
   pnprt_ser_e ser_q, ser_d;
   logic sclk_prev_q, sclk_prev_d;
   logic [SERIAL_CNT_BITS-1:0] cnt_q, cnt_d;
   logic [WORD_BITS-1:0] shift_q, shift_d;
   logic [SERIAL_CMD_BITS-1:0] scmd_q, scmd_d;
   logic sout_q, sout_d;
   logic rise, ser_we;
   logic [WORD_BITS-1:0] ser_word;
   logic [SERIAL_ADDR_BITS-1:0] ser_addr;

   always_comb begin
      sclk_prev_d = serial_port_clock;
      rise = serial_port_clock && !sclk_prev_q;
      ser_d = ser_q;
      cnt_d = cnt_q;
      shift_d = shift_q;
      scmd_d = scmd_q;
      sout_d = sout_q;
      ser_we = 1'b0;
      ser_word = shift_q;
      ser_addr = scmd_q[SERIAL_ADDR_BITS-1:0];
      if (!serial_port_select) begin
         ser_d = SER_IDLE;
         sout_d = 1'b0;
      end else if (rise) begin
         case (ser_q)
            SER_IDLE: begin
               cnt_d = '0;
               if (serial_port_in) begin
                  ser_d = SER_CMD;
               end
            end
            SER_CMD: begin
               scmd_d = {scmd_q[SERIAL_CMD_BITS-2:0], serial_port_in};
               cnt_d = cnt_q + SERIAL_CNT_BITS'(1);
               ser_addr = scmd_d[SERIAL_ADDR_BITS-1:0];
               if (cnt_q == SERIAL_CNT_BITS'(SERIAL_CMD_BITS - 1)) begin
                  cnt_d = '0;
                  case (scmd_d[SERIAL_CMD_BITS-1 -: 2])
                     OP_READ: begin
                        ser_d = SER_OUT;
                        shift_d = store_mem[{1'b0, ser_addr}];
                        sout_d = 1'b0;
                     end
                     OP_WRITE: ser_d = SER_IN;
                     OP_ERASE: begin
                        ser_we = 1'b1;
                        ser_word = ERASED_WORD;
                        ser_d = SER_IDLE;
                     end
                     default: ser_d = SER_IDLE;
                  endcase
               end
            end
            SER_OUT: begin
               sout_d = shift_q[WORD_BITS-1];
               shift_d = {shift_q[WORD_BITS-2:0], 1'b0};
               cnt_d = cnt_q + SERIAL_CNT_BITS'(1);
               if (cnt_q == SERIAL_CNT_BITS'(WORD_BITS)) begin
                  ser_d = SER_IDLE;
                  sout_d = 1'b0;
               end
            end
            SER_IN: begin
               shift_d = {shift_q[WORD_BITS-2:0], serial_port_in};
               cnt_d = cnt_q + SERIAL_CNT_BITS'(1);
               if (cnt_q == SERIAL_CNT_BITS'(WORD_BITS - 1)) begin
                  ser_we = 1'b1;
                  ser_word = shift_d;
                  ser_d = SER_IDLE;
               end
            end
            default: ser_d = SER_IDLE;
         endcase
      end
      // Host commit owns the single write port
      mem_we = host_we || ser_we;
      mem_waddr = host_we ? host_addr : {1'b0, ser_addr};
      mem_wdata = host_we ? host_word : ser_word;
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ser_q <= SER_IDLE;
         sclk_prev_q <= 1'b0;
         cnt_q <= '0;
         shift_q <= '0;
         scmd_q <= '0;
         sout_q <= 1'b0;
      end else begin
         ser_q <= ser_d;
         sclk_prev_q <= sclk_prev_d;
         cnt_q <= cnt_d;
         shift_q <= shift_d;
         scmd_q <= scmd_d;
         sout_q <= sout_d;
      end
   end
   assign serial_port_out = sout_q;
endmodule

// *** bench/pnprt_checker.sv ***
// Port assertions for the routing, chip select and store block
`timescale 1ns/1ns
module pnprt_checker
   import pnprt_pkg::*;
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [11:0] sa,
   input wire logic iord_n,
   input wire logic iowr_n,
   input wire logic aen,
   input wire logic config_state,
   input wire logic [7:0] reg_index,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic [1:0] mode_select_bits,
   input wire logic [2:0] irq_route0,
   input wire logic irq_enable0,
   input wire logic dma_enable,
   input wire logic dma_channel,
   input wire logic [15:0] cs_base0,
   input wire logic [15:0] cs_mask0,
   input wire logic [2:0] cs_enable,
   input wire logic [2:0] cs_qualify,
   input wire logic [1:0] board_irq_in,
   input wire logic board_dma_req,
   input wire logic board_dma_ack_n,
   input wire logic [5:0] host_irq_out,
   input wire logic [1:0] host_dma_req_out,
   input wire logic [1:0] host_dma_ack_in_n,
   input wire logic [1:0] card_chip_select_n,
   input wire logic serial_port_select,
   input wire logic serial_port_out
);
   // ----------
   // Assertions
   // ----------
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   wire dma_m = mode_select_bits == MODE_DMA;
   wire hit0 = ((({4'h0, sa} ^ cs_base0) & cs_mask0) == 16'h0000);
   irq_route_a: assert property (dma_m && irq_enable0 && board_irq_in[0]
      && irq_route0 < 3'h6 |-> host_irq_out[irq_route0]) else $error("irq not routed");
   dma_route_a: assert property (dma_m && dma_enable && board_dma_req |->
      host_dma_req_out[dma_channel] && board_dma_ack_n == host_dma_ack_in_n[dma_channel])
      else $error("dma not routed");
   ext_irq_a: assert property (mode_select_bits == MODE_EXT_IRQ && irq_enable0
      && board_irq_in[0] && irq_route0[2:1] == 2'h3 |-> host_dma_req_out[irq_route0[0]])
      else $error("extra irq not routed");
   cs_match_a: assert property (dma_m && cs_enable[0] && !cs_qualify[0] && !aen
      && hit0 |-> !card_chip_select_n[0]) else $error("select missing");
   cs_strobe_a: assert property (cs_enable[1] && cs_qualify[1] && iord_n && iowr_n
      |-> card_chip_select_n[1]) else $error("select without strobe");
   aen_block_a: assert property (aen |-> card_chip_select_n == 2'h3)
      else $error("select during dma cycle");
   busy_flag_a: assert property (reg_wr && config_state && reg_index == REG_COMMAND
      && reg_wdata[2] && reg_wdata[1:0] == OP_WRITE ##2 reg_rd && reg_index == REG_STATUS
      |=> !reg_rdata[0]) else $error("busy not shown");
   cfg_gate_a: assert property (reg_rd && !config_state && reg_index[7:2] == 6'h3c
      |=> reg_rdata == 8'h00) else $error("register open outside config");
   rsvd_zero_a: assert property (reg_rd && config_state && reg_index == REG_COMMAND
      |=> reg_rdata[6:3] == 4'h0) else $error("reserved bits set");
   ser_idle_a: assert property (!serial_port_select [*2] |-> !serial_port_out)
      else $error("serial out while idle");
   cover property (reg_rd && reg_index == REG_STATUS ##1 reg_rdata[0]);
   cover property (!card_chip_select_n[0] && !iord_n);
   cover property (serial_port_select && serial_port_out);
endmodule

// *** bench/pnprt_serial_model.sv ***
// On-board serial master that reads, writes and erases the shared store
`timescale 1ns/1ns
module pnprt_serial_model
   import pnprt_pkg::*;
(
   input wire logic sys_clk,
   input wire logic serial_port_out,
   output logic serial_port_select,
   output logic serial_port_clock,
   output logic serial_port_in
);
   initial begin
      serial_port_select = 1'b0;
      serial_port_clock = 1'b0;
      serial_port_in = 1'b0;
   end
   // Start bit, opcode, address, data (none for erase); clock stands still between frames
   task automatic xfer(input logic [1:0] op, input logic [7:0] a, input logic [15:0] w,
      output logic [15:0] r);
      logic [26:0] f;
      int i;
      int last;
      f = {1'b1, op, a, w};
      last = (op == OP_ERASE) ? 16 : 0;
      @(negedge sys_clk);
      serial_port_select = 1'b1;
      for (i = 26; i >= last; i--) begin
         serial_port_in = f[i];
         repeat (2) @(negedge sys_clk);
         serial_port_clock = 1'b1;
         repeat (2) @(negedge sys_clk);
         if (i < 16) r[i] = serial_port_out;
         serial_port_clock = 1'b0;
      end
      serial_port_select = 1'b0;
      serial_port_in = ~serial_port_in;
   endtask
endmodule

// *** bench/pnprt_bench.sv ***
// Self-checking bench for the routing, chip select and store block
`timescale 1ns/1ns
module pnprt_bench;
   import pnprt_pkg::*;
   localparam int PC = 20;
   logic sys_clk = 1'b0, arst_n = 1'b0, iord_n = 1'b1, iowr_n = 1'b1, aen = 1'b0;
   logic config_state = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, irq_enable0 = 1'b1;
   logic irq_enable1 = 1'b1, dma_enable = 1'b1, dma_channel = 1'b0, board_dma_req = 1'b0;
   logic [11:0] sa = 12'h000;
   logic [7:0] reg_index = 8'h00, reg_wdata = 8'h00, reg_rdata, rb;
   logic [1:0] mode_select_bits = 2'h0, board_irq_in = 2'h0, host_dma_ack_in_n = 2'h3;
   logic [2:0] irq_route0 = 3'h0, irq_route1 = 3'h0, cs_enable = 3'h0, cs_qualify = 3'h2;
   logic [15:0] cs_base0 = 16'h0300, cs_base1 = 16'h0310, cs_base2 = 16'ha200, got;
   logic [15:0] cs_mask0 = 16'hfff0, cs_mask1 = 16'hfff0, cs_mask2 = 16'hff00;
   logic [5:0] host_irq_out;
   logic [1:0] host_dma_req_out, card_chip_select_n;
   logic board_dma_ack_n, serial_port_select, serial_port_clock, serial_port_in;
   logic serial_port_out;
   int err_count = 0, tests_run = 0, cyc = 0, t0, n, r;
   pnprt_top #(.PROG_CYCLES(PC)) dut (.*);
   pnprt_serial_model ser (.*);
   initial forever #4 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         results();
      end
   end
   // ----------------
   // Shared tasks
   // ----------------
   task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("BAD %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      @(negedge sys_clk);
      {reg_index, reg_wdata, reg_wr} = {i, d, 1'b1};
      @(negedge sys_clk);
      reg_wr = 1'b0;
      t0 = cyc;
   endtask
   task automatic rd(input logic [7:0] i, output logic [7:0] d);
      @(negedge sys_clk);
      {reg_index, reg_rd} = {i, 1'b1};
      @(negedge sys_clk);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask
   task automatic load(input logic [7:0] c, input logic [7:0] a, input logic [15:0] w);
      wr(REG_DATA_LOW, w[7:0]);
      wr(REG_DATA_HIGH, w[15:8]);
      wr(REG_ADDR_LOW, a);
      wr(REG_COMMAND, c);
   endtask
   task automatic poll();
      rb = 8'h00;
      while (rb[0] !== 1'b1 && cyc - t0 < PC + 40) rd(REG_STATUS, rb);
      n = cyc - t0;
      chk(16'(rb[0]), 16'h1, "poll done");
   endtask
   task automatic hread(input logic [7:0] c, input logic [7:0] a, output logic [15:0] w);
      load(c, a, 16'h0000);
      poll();
      rd(REG_DATA_HIGH, w[15:8]);
      rd(REG_DATA_LOW, w[7:0]);
   endtask
   // ----------------
   // Scenarios
   // ----------------
   // Inputs change at a falling edge; outputs are judged at the next falling edge
   task automatic t_route();
      @(negedge sys_clk) board_dma_req = 1'b1;
      for (r = 0; r < 6; r++) begin
         {irq_route0, irq_route1, board_irq_in} = {3'(r), 3'(5 - r), 2'h1};
         @(negedge sys_clk);
         chk(16'(host_irq_out), 16'h1 << r, "irq0");
         board_irq_in = 2'h2;
         @(negedge sys_clk);
         chk(16'(host_irq_out), 16'h1 << (5 - r), "irq1");
      end
      for (r = 0; r < 2; r++) begin
         {dma_channel, host_dma_ack_in_n} = {1'(r), ~(2'h1 << r)};
         @(negedge sys_clk);
         chk({host_dma_req_out, board_dma_ack_n}, 16'(2'h1 << r) << 1, "dma");
      end
      {mode_select_bits, board_irq_in} = {MODE_EXT_IRQ, 2'h1};
      for (r = 6; r < 8; r++) begin
         irq_route0 = 3'(r);
         @(negedge sys_clk);
         chk(16'(host_dma_req_out), 16'h1 << (r - 6), "extra irq");
      end
   endtask
   task automatic t_cs();
      {mode_select_bits, cs_enable, sa} = {MODE_DMA, 3'h3, 12'h305};
      @(negedge sys_clk);
      chk(16'(card_chip_select_n), 16'h2, "cs0");
      sa = 12'h31a;
      @(negedge sys_clk);
      chk(16'(card_chip_select_n), 16'h3, "cs1 idle");
      iord_n = 1'b0;
      @(negedge sys_clk);
      chk(16'(card_chip_select_n), 16'h1, "cs1 read");
      aen = 1'b1;
      @(negedge sys_clk);
      chk(16'(card_chip_select_n), 16'h3, "aen");
      {aen, iord_n, mode_select_bits, cs_enable, sa} = {2'h1, MODE_EXT_IRQ, 3'h4, 12'h2ab};
      {board_dma_req, board_irq_in, host_dma_ack_in_n} = 5'b10010;
      @(negedge sys_clk);
      chk(16'(board_dma_ack_n), 16'h0, "cs2 hit");
      board_dma_req = 1'b0;
      @(negedge sys_clk);
      chk(16'(board_dma_ack_n), 16'h1, "cs2 miss");
      {mode_select_bits, host_dma_ack_in_n} = {MODE_DMA, 2'h3};
   endtask
   task automatic t_prog();
      load(8'h7d, 8'h12, 16'h5a3c);
      rd(REG_STATUS, rb);
      chk(16'(rb[0]), 16'h0, "busy");
      wr(REG_ADDR_LOW, 8'hee);
      t0 = t0 - 4;
      poll();
      chk(16'(n >= PC && n <= PC + 4), 16'h1, "prog time");
      rd(REG_ADDR_LOW, rb);
      chk(16'(rb), 16'h12, "write while busy");
      rd(REG_COMMAND, rb);
      chk(16'(rb), 16'h01, "command");
      ser.xfer(OP_READ, 8'h12, 16'h0000, got);
      chk(got, 16'h5a3c, "serial read");
      load(8'h85, 8'h60, 16'hc0de);
      poll();
      hread(8'h86, 8'h60, got);
      chk(got, 16'hc0de, "high half");
      load(8'h01, 8'h12, 16'h0000);
      rd(REG_STATUS, rb);
      chk(16'(rb[0]), 16'h1, "no proceed");
      load(8'h07, 8'h12, 16'h0000);
      poll();
      ser.xfer(OP_READ, 8'h12, 16'h0000, got);
      chk(got, ERASED_WORD, "host erase");
   endtask
   task automatic t_ser();
      ser.xfer(OP_WRITE, 8'h34, 16'ha5c3, got);
      hread(8'h06, 8'h34, got);
      chk(got, 16'ha5c3, "serial write");
      ser.xfer(OP_ERASE, 8'h34, 16'h0000, got);
      hread(8'h06, 8'h34, got);
      chk(got, ERASED_WORD, "serial erase");
      config_state = 1'b0;
      rd(REG_ADDR_LOW, rb);
      chk(16'(rb), 16'h00, "closed read");
      wr(REG_ADDR_LOW, 8'h77);
      rd(REG_STATUS, rb);
      chk(16'(rb[0]), 16'h1, "status open");
      config_state = 1'b1;
      rd(REG_ADDR_LOW, rb);
      chk(16'(rb), 16'h34, "closed write");
      rd(8'h40, rb);
      chk(16'(rb), 16'h00, "unmapped");
   endtask
   task automatic results();
      $display("tests_run %0d err_count %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk) arst_n = 1'b1;
      rd(REG_STATUS, rb);
      chk(16'(rb), 16'h01, "reset status");
      t_route();
      t_cs();
      t_prog();
      t_ser();
      results();
   end
endmodule
bind pnprt_top pnprt_checker chk_i (.*);
